// ### host_port_pkg.sv
// constants and types shared by the parallel host port, its checker and its bench
// assumes the surrounding core supplies the display timing blank levels
// How it works
// - strap low selects 6800 style enable and direction strobes.
// - strap high selects 8080 style separate read and write strobes.
// - 6800 with enable high: chip select rising edge captures the bus.
// - 6800 with chip select low: enable falling edge captures the bus.
// - 8080 write: write strobe low with select low, captured on its rise.
// - 8080 read begins at read strobe low, ends at its rise.
// - commands and register accesses use only bus lines 7 to 0; register reads also drive lines 23 to 8 low.
// - upper bus lines carry pixel data only, never commands or parameters.
// - pixel packing is chosen by the pixel interface configuration command.
// - widths 8, 9, 16, 18 and 24 bits are supported in both styles.
// - pixels are unpacked from one or more cycles per width; don't-cares ignored.
// - tear indicator high during non-display, low during active lines.
// - tear indicator reflects vertical only or vertical plus horizontal blank.
// - tear indicator comes from display timing blank levels; port combines and registers them.
// - commands rejected in reset and deep sleep, accepted in sleep and display.
// - each frame buffer access steps the address counter up or down by one.
package host_port_pkg;
    localparam int BUS_W = 24;
    localparam int PIX_W = 24;
    localparam int ADDR_W = 21;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] CMD_WRITE_MEM_START = 8'h2c;
    localparam logic [7:0] CMD_READ_MEM_START = 8'h2e;
    localparam logic [7:0] CMD_WRITE_MEM_CONT = 8'h3c;
    localparam logic [7:0] CMD_READ_MEM_CONT = 8'h3e;
    localparam logic [7:0] CMD_PIXEL_IF = 8'hf0;
    localparam logic [2:0] PIF_8 = 3'h0;
    localparam logic [2:0] PIF_12 = 3'h1;
    localparam logic [2:0] PIF_16 = 3'h2;
    localparam logic [2:0] PIF_16_565 = 3'h3;
    localparam logic [2:0] PIF_18 = 3'h4;
    localparam logic [2:0] PIF_24 = 3'h5;
    localparam logic [2:0] PIF_9 = 3'h6;
    localparam logic [2:0] PIF_RESET = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
    typedef enum logic [1:0] {
        PWR_RESET,
        PWR_DEEP_SLEEP,
        PWR_SLEEP,
        PWR_DISPLAY
    } power_state_t;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WRITE_MEM,
        ACC_READ_MEM,
        ACC_PARAM
    } access_t;
endpackage

// ### pixel_fifo.sv
// pixel fifo between the host port and the frame buffer write side
// assumes both sides on sys_clk; storage in flip-flops
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("pixel_fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic do_wr, do_rd;
    always_comb begin
        in_ready = (wr_ff - rd_ff) != DEPTH[AW:0];
        out_valid = wr_ff != rd_ff;
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        nxt_wr = wr_ff + (AW+1)'(do_wr);
        nxt_rd = rd_ff + (AW+1)'(do_rd);
        out_data = mem_ff[rd_ff[AW-1:0]];
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end
    // data storage needs no reset; emptiness is tracked by the pointers
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule // pixel_fifo
`default_nettype wire

// ### host_port.sv
// parallel host port: strobe decode, command/parameter split, pixel unpack
// assumes pins are asynchronous to sys_clk; frame buffer and timing sit outside
`timescale 1ns/1ps
`default_nettype none
module host_port #(
    parameter int FIFO_DEPTH = host_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host pins
    input wire logic mode_strap,
    input wire logic cs_n,
    input wire logic dc_sel,
    input wire logic en_rd_n,
    input wire logic rw_wr_n,
    input wire logic [host_port_pkg::BUS_W-1:0] bus_in,
    output logic [host_port_pkg::BUS_W-1:0] bus_out,
    output logic [host_port_pkg::BUS_W-1:0] bus_oe_n,
    output logic tear_indicator,
    // power manager and address mode
    input wire host_port_pkg::power_state_t power_state,
    input wire logic addr_decrement,
    // display timing
    input wire logic vertical_blank_window,
    input wire logic horiz_blank,
    input wire logic tear_with_horiz,
    // command and parameter bytes to the core
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic param_valid,
    output logic [7:0] param_byte,
    output logic [7:0] param_cmd,
    input wire logic [7:0] reg_read_byte,
    // frame buffer side
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [host_port_pkg::PIX_W-1:0] pix_data,
    output logic [host_port_pkg::ADDR_W-1:0] fb_addr,
    output logic fb_read_req,
    input wire logic [host_port_pkg::PIX_W-1:0] fb_read_data,
    output logic pix_stall,
    output logic [2:0] pixel_if
);
    // pins pass two flops before use
    logic [4:0] s1_ff, s2_ff, ctl_q_ff;
    logic [23:0] d1_ff, d2_ff;
    logic mode_8080, cs, dc, e_rd, rw_wr;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= 5'h1f;
            s2_ff <= 5'h1f;
            ctl_q_ff <= 5'h1f;
            d1_ff <= 24'h000000;
            d2_ff <= 24'h000000;
        end else begin
            s1_ff <= {mode_strap, cs_n, dc_sel, en_rd_n, rw_wr_n};
            s2_ff <= s1_ff;
            ctl_q_ff <= s2_ff;
            d1_ff <= bus_in;
            d2_ff <= d1_ff;
        end
    end
    always_comb begin
        {mode_8080, cs, dc, e_rd, rw_wr} = s2_ff;
    end
    // strobe edges, seen in the sync domain; data is taken from the same stage
    logic wr_strobe, rd_begin, rd_end;
    always_comb begin
        wr_strobe = 1'b0;
        rd_begin = 1'b0;
        rd_end = 1'b0;
        if (mode_8080) begin
            wr_strobe = rw_wr && !ctl_q_ff[0] && !cs;
            rd_begin = !e_rd && ctl_q_ff[1] && !cs;
            rd_end = e_rd && !ctl_q_ff[1];
        end else begin
            // chip-select clocked style when enable is high
            if (e_rd && cs && !ctl_q_ff[3]) begin
                wr_strobe = !rw_wr;
                rd_end = rw_wr;
            end
            // enable clocked style when chip select is low
            if (!cs && !e_rd && ctl_q_ff[1]) begin
                wr_strobe = !rw_wr;
                rd_end = rw_wr;
            end
            rd_begin = rw_wr && !cs && e_rd && (ctl_q_ff[1] == 1'b0 || ctl_q_ff[3]);
        end
    end
    logic accepting;
    always_comb begin
        // clock generator is stopped in reset and deep sleep
        accepting = power_state == host_port_pkg::PWR_SLEEP
                 || power_state == host_port_pkg::PWR_DISPLAY;
    end
    // access state, pixel format, address counter, unpacking
    host_port_pkg::access_t acc_ff, nxt_acc;
    logic [2:0] pif_ff, nxt_pif;
    logic [7:0] last_cmd_ff, nxt_last_cmd;
    logic [host_port_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    logic [1:0] phase_ff, nxt_phase;
    logic [23:0] acc_pix_ff, nxt_acc_pix;
    logic cmd_v_ff, nxt_cmd_v, par_v_ff, nxt_par_v;
    logic [7:0] cmd_b_ff, nxt_cmd_b, par_b_ff, nxt_par_b;
    logic push;
    logic [23:0] push_data;
    logic fifo_in_ready;
    logic [23:0] rd_ff, nxt_rd;
    logic rd_drive_ff, nxt_rd_drive, fb_rreq_ff, nxt_fb_rreq;
    function automatic logic [23:0] unpack(input logic [2:0] fmt, input logic [1:0] ph,
                                           input logic [23:0] acc, input logic [23:0] d,
                                           output logic done);
        logic [23:0] r;
        r = acc;
        done = 1'b0;
        unique case (fmt)
            host_port_pkg::PIF_24: begin
                r = d;
                done = 1'b1;
            end
            host_port_pkg::PIF_18: begin
                r = {d[17:12], 2'b00, d[11:6], 2'b00, d[5:0], 2'b00};
                done = 1'b1;
            end
            host_port_pkg::PIF_16_565: begin
                r = {d[15:11], 3'b000, d[10:5], 2'b00, d[4:0], 3'b000};
                done = 1'b1;
            end
            host_port_pkg::PIF_9: begin
                // first cycle red and upper green, second lower green and blue
                if (ph == 2'd0) begin
                    r = {d[8:3], 2'b00, d[2:0], 5'h00, 8'h00};
                end else begin
                    r = {acc[23:13], d[8:6], 2'b00, d[5:0], 2'b00};
                    done = 1'b1;
                end
            end
            host_port_pkg::PIF_16: begin
                // three cycles carry two pixels; emit one per completed pixel
                unique case (ph)
                    2'd0: r = {d[15:8], d[7:0], 8'h00};
                    2'd1: begin
                        r = {acc[23:8], d[15:8]};
                        done = 1'b1;
                    end
                    default: begin
                        // second pixel: red was held over from the middle cycle
                        r = {acc[23:16], d[15:0]};
                        done = 1'b1;
                    end
                endcase
            end
            default: begin
                // 8-bit bus: three byte cycles red, green, blue
                unique case (ph)
                    2'd0: r = {d[7:0], 16'h0000};
                    2'd1: r = {acc[23:16], d[7:0], 8'h00};
                    default: begin
                        r = {acc[23:8], d[7:0]};
                        done = 1'b1;
                    end
                endcase
            end
        endcase
        return r;
    endfunction
    logic pix_done;
    logic [23:0] pix_word;
    always_comb begin
        nxt_acc = acc_ff;
        nxt_pif = pif_ff;
        nxt_last_cmd = last_cmd_ff;
        nxt_addr = addr_ff;
        nxt_phase = phase_ff;
        nxt_acc_pix = acc_pix_ff;
        nxt_cmd_v = 1'b0;
        nxt_par_v = 1'b0;
        nxt_cmd_b = cmd_b_ff;
        nxt_par_b = par_b_ff;
        nxt_rd = rd_ff;
        nxt_rd_drive = rd_drive_ff;
        nxt_fb_rreq = 1'b0;
        push = 1'b0;
        push_data = acc_pix_ff;
        pix_word = unpack(pif_ff, phase_ff, acc_pix_ff, d2_ff, pix_done);
        if (wr_strobe && accepting) begin
            if (!dc) begin
                nxt_cmd_b = d2_ff[7:0];
                nxt_cmd_v = 1'b1;
                nxt_last_cmd = d2_ff[7:0];
                nxt_phase = 2'd0;
                unique case (d2_ff[7:0])
                    host_port_pkg::CMD_WRITE_MEM_START,
                    host_port_pkg::CMD_WRITE_MEM_CONT: nxt_acc = host_port_pkg::ACC_WRITE_MEM;
                    host_port_pkg::CMD_READ_MEM_START,
                    host_port_pkg::CMD_READ_MEM_CONT: nxt_acc = host_port_pkg::ACC_READ_MEM;
                    default: nxt_acc = host_port_pkg::ACC_PARAM;
                endcase
                if (d2_ff[7:0] == host_port_pkg::CMD_WRITE_MEM_START
                    || d2_ff[7:0] == host_port_pkg::CMD_READ_MEM_START) begin
                    nxt_addr = host_port_pkg::ADDR_RESET;
                end
            end else if (acc_ff == host_port_pkg::ACC_WRITE_MEM) begin
                // the middle 16-bit cycle's low byte is the next pixel's red
                nxt_acc_pix = (pif_ff == host_port_pkg::PIF_16 && phase_ff == 2'd1)
                            ? {d2_ff[7:0], 16'h0000} : pix_word;
                nxt_phase = (pix_done && pif_ff != host_port_pkg::PIF_16) ? 2'd0
                          : (phase_ff == 2'd2 ? 2'd0 : phase_ff + 2'd1);
                if (pix_done) begin
                    push = 1'b1;
                    push_data = pix_word;
                    nxt_addr = addr_decrement ? addr_ff - 21'h1 : addr_ff + 21'h1;
                end
            end else begin
                // parameters ride only on the low byte
                nxt_par_b = d2_ff[7:0];
                nxt_par_v = 1'b1;
                if (last_cmd_ff == host_port_pkg::CMD_PIXEL_IF) begin
                    nxt_pif = d2_ff[2:0];
                end
            end
        end
        if (rd_begin && accepting) begin
            nxt_rd_drive = 1'b1;
            if (dc && acc_ff == host_port_pkg::ACC_READ_MEM) begin
                nxt_rd = fb_read_data;
                nxt_fb_rreq = 1'b1;
                nxt_addr = addr_decrement ? addr_ff - 21'h1 : addr_ff + 21'h1;
            end else begin
                nxt_rd = {16'h0000, reg_read_byte};
            end
        end
        if (rd_end) begin
            nxt_rd_drive = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= host_port_pkg::ACC_IDLE;
            pif_ff <= host_port_pkg::PIF_RESET;
            last_cmd_ff <= 8'h00;
            addr_ff <= host_port_pkg::ADDR_RESET;
            phase_ff <= 2'd0;
            acc_pix_ff <= 24'h000000;
            cmd_v_ff <= 1'b0;
            par_v_ff <= 1'b0;
            cmd_b_ff <= 8'h00;
            par_b_ff <= 8'h00;
            rd_ff <= 24'h000000;
            rd_drive_ff <= 1'b0;
            fb_rreq_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            pif_ff <= nxt_pif;
            last_cmd_ff <= nxt_last_cmd;
            addr_ff <= nxt_addr;
            phase_ff <= nxt_phase;
            acc_pix_ff <= nxt_acc_pix;
            cmd_v_ff <= nxt_cmd_v;
            par_v_ff <= nxt_par_v;
            cmd_b_ff <= nxt_cmd_b;
            par_b_ff <= nxt_par_b;
            rd_ff <= nxt_rd;
            rd_drive_ff <= nxt_rd_drive;
            fb_rreq_ff <= nxt_fb_rreq;
        end
    end
    // a push while full is lost; pix_stall tells the core to hold off the host
    pixel_fifo #(
        .WIDTH(host_port_pkg::PIX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_data)
    );
    logic tear_ff;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tear_ff <= 1'b0;
        end else begin
            // blank levels come from timing logic on this clock
            tear_ff <= vertical_blank_window || (tear_with_horiz && horiz_blank);
        end
    end
    always_comb begin
        cmd_valid = cmd_v_ff;
        cmd_byte = cmd_b_ff;
        param_valid = par_v_ff;
        param_byte = par_b_ff;
        param_cmd = last_cmd_ff;
        fb_addr = addr_ff;
        fb_read_req = fb_rreq_ff;
        pix_stall = !fifo_in_ready;
        pixel_if = pif_ff;
        bus_out = rd_ff;
        bus_oe_n = rd_drive_ff ? 24'h000000 : 24'hffffff;
        tear_indicator = tear_ff;
    end
endmodule // host_port
`default_nettype wire

// ### host_port_properties.sv
// checker on the host port boundary, bound onto host_port from the bench top
// assumes one clock, sys_clk, and rst_n asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module host_port_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host pins
    input wire logic mode_strap,
    input wire logic cs_n,
    input wire logic en_rd_n,
    input wire logic rw_wr_n,
    input wire logic [23:0] bus_oe_n,
    input wire logic tear_indicator,
    // core side
    input wire host_port_pkg::power_state_t power_state,
    input wire logic addr_decrement,
    input wire logic vertical_blank_window,
    input wire logic horiz_blank,
    input wire logic tear_with_horiz,
    input wire logic cmd_valid,
    input wire logic param_valid,
    input wire logic pix_stall,
    input wire logic [20:0] fb_addr,
    input wire logic [2:0] pixel_if
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic awake;
    assign awake = power_state inside {host_port_pkg::PWR_SLEEP, host_port_pkg::PWR_DISPLAY};
    chk_tear_route: assert property ($past(rst_n) |->
        tear_indicator == $past(vertical_blank_window | (tear_with_horiz & horiz_blank)))
        else $error("tear indicator not the registered blank levels");
    chk_cmd_single: assert property (cmd_valid |-> !param_valid ##1 !cmd_valid)
        else $error("command strobe overlaps or lasts too long");
    chk_param_single: assert property (param_valid |=> !param_valid)
        else $error("parameter strobe lasts too long");
    chk_sleep_gate: assert property (!awake [*5] |-> !cmd_valid && !param_valid)
        else $error("transfer accepted with the clock generator stopped");
    chk_pins_quiet: assert property (($stable(cs_n) && $stable(en_rd_n)
        && $stable(rw_wr_n)) [*5] |-> !cmd_valid && !param_valid)
        else $error("transfer without any strobe edge");
    chk_read_release: assert property ((mode_strap && en_rd_n) [*5] |-> &bus_oe_n)
        else $error("bus driven outside a read");
    chk_addr_step: assert property ($changed(fb_addr) && !cmd_valid && !$past(cmd_valid)
        |-> fb_addr == $past(fb_addr) + ($past(addr_decrement) ? 21'h1fffff : 21'h000001))
        else $error("address counter moved by other than one");
    chk_format_cause: assert property ($changed(pixel_if)
        |-> param_valid)
        else $error("pixel format changed without a parameter");
    cover property (pix_stall);
    cover property (!bus_oe_n[0]);
    cover property ($rose(tear_indicator));
endmodule // host_port_properties
`default_nettype wire

// ### host_mcu_model.sv
// host microcontroller model writing the parallel pins in either strobe style, reading in 8080 style only
// assumes tasks are called from a process that runs just after a sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    // clock
    input wire logic sys_clk,
    // pins
    output logic mode_strap,
    output logic cs_n,
    output logic dc_sel,
    output logic en_rd_n,
    output logic rw_wr_n,
    output logic [23:0] bus_in,
    input wire logic [23:0] bus_out,
    input wire logic [23:0] bus_oe_n
);
    initial begin
        mode_strap = 1'b1;
        cs_n = 1'b1;
        dc_sel = 1'b0;
        en_rd_n = 1'b1;
        rw_wr_n = 1'b1;
        bus_in = 24'h000000;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // style 0: separate strobes, 1: select as bus clock, 2: enable as clock
    // idle levels settle before select moves, so no stray edge is taken
    task automatic write(input int style, input logic dc, input logic [23:0] d);
        mode_strap = (style == 0);
        dc_sel = dc;
        bus_in = d;
        rw_wr_n = (style == 0);
        en_rd_n = (style != 2);
        step(4);
        cs_n = (style == 1);
        step(4);
        if (style == 0) rw_wr_n = 1'b0;
        else if (style == 1) cs_n = 1'b0;
        else en_rd_n = 1'b1;
        step(4);
        if (style == 0) rw_wr_n = 1'b1;
        else if (style == 1) cs_n = 1'b1;
        else en_rd_n = 1'b0;
        step(4);
        cs_n = 1'b1;
        bus_in = ~d;
        step(1);
    endtask
    task automatic read(output logic [23:0] q, output logic [23:0] oe);
        mode_strap = 1'b1;
        dc_sel = 1'b1;
        rw_wr_n = 1'b1;
        en_rd_n = 1'b1;
        bus_in = ~bus_in;
        step(4);
        cs_n = 1'b0;
        step(4);
        en_rd_n = 1'b0;
        step(6);
        q = bus_out;
        oe = bus_oe_n;
        en_rd_n = 1'b1;
        step(4);
        cs_n = 1'b1;
        step(6);
    endtask
endmodule // host_mcu_model
`default_nettype wire

// ### host_port_tb_top.sv
// self-checking bench: host model on the pins, queue scoreboard on the core side
// assumes the package, design, model and checker compile before this file
`timescale 1ns/1ps
`default_nettype none
module host_port_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode_strap, cs_n, dc_sel, en_rd_n, rw_wr_n, tear_indicator;
    logic [23:0] bus_in, bus_out, bus_oe_n, pix_data, fb_read_data = 24'h000000;
    host_port_pkg::power_state_t power_state = host_port_pkg::PWR_DISPLAY;
    logic addr_decrement = 1'b0;
    logic vertical_blank_window = 1'b0, horiz_blank = 1'b0, tear_with_horiz = 1'b0;
    logic cmd_valid, param_valid, pix_valid, fb_read_req, pix_stall;
    logic pix_ready = 1'b0;
    logic [7:0] cmd_byte, param_byte, param_cmd, reg_read_byte = 8'h00, last_cmd = 8'h00;
    logic [20:0] fb_addr;
    logic [2:0] pixel_if;
    logic [31:0] seed = 32'h00000006;
    int errors = 0;
    int checked = 0;
    int fb_reqs = 0;
    logic [7:0] exp_cmd[$], exp_par[$];
    logic [23:0] exp_pix[$];
    host_port #(.FIFO_DEPTH(32)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .mode_strap(mode_strap), .cs_n(cs_n), .dc_sel(dc_sel), .en_rd_n(en_rd_n),
        .rw_wr_n(rw_wr_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
        .tear_indicator(tear_indicator), .power_state(power_state),
        .addr_decrement(addr_decrement), .vertical_blank_window(vertical_blank_window),
        .horiz_blank(horiz_blank), .tear_with_horiz(tear_with_horiz),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .param_valid(param_valid),
        .param_byte(param_byte), .param_cmd(param_cmd), .reg_read_byte(reg_read_byte),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .fb_addr(fb_addr), .fb_read_req(fb_read_req), .fb_read_data(fb_read_data),
        .pix_stall(pix_stall), .pixel_if(pixel_if));
    host_mcu_model u_host (.sys_clk(sys_clk), .mode_strap(mode_strap), .cs_n(cs_n),
        .dc_sel(dc_sel), .en_rd_n(en_rd_n), .rw_wr_n(rw_wr_n), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe_n(bus_oe_n));
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic rnd(output logic [31:0] r);
        seed = xs(seed);
        r = seed;
    endtask
    // blank levels wander every cycle so the tear path sees every combination
    always @(posedge sys_clk) begin
        #2;
        seed = xs(seed);
        {vertical_blank_window, horiz_blank, tear_with_horiz} = seed[2:0];
        fb_read_data = seed[31:8];
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (cmd_valid === 1'b1) begin
            if (exp_cmd.size() == 0) check("cmd_extra", 24'h0, 24'h1);
            else check("cmd_byte", {16'h0, exp_cmd.pop_front()}, {16'h0, cmd_byte});
        end
        if (param_valid === 1'b1) begin
            if (exp_par.size() == 0) check("param_extra", 24'h0, 24'h1);
            else check("param_byte", {16'h0, exp_par.pop_front()}, {16'h0, param_byte});
            check("param_cmd", {16'h0, last_cmd}, {16'h0, param_cmd});
        end
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            if (exp_pix.size() == 0) check("pix_extra", 24'h0, 24'h1);
            else check("pix_data", exp_pix.pop_front(), pix_data);
        end
        if (fb_read_req === 1'b1) fb_reqs++;
    end
    // upper lines carry noise on every command or parameter byte
    task automatic xfer(input int style, input logic dc, input logic [7:0] b);
        logic [31:0] r;
        rnd(r);
        if (power_state inside {host_port_pkg::PWR_SLEEP, host_port_pkg::PWR_DISPLAY}) begin
            if (dc) exp_par.push_back(b);
            else begin
                exp_cmd.push_back(b);
                last_cmd = b;
            end
        end
        u_host.write(style, dc, {r[23:8], b});
    endtask
    // a fast host opens frame updates in blank, a slow one behind the scan
    task automatic wait_blank(input logic lvl);
        int n;
        for (n = 0; n < 64 && tear_indicator !== lvl; n++) u_host.step(1);
        if (tear_indicator !== lvl) begin
            errors++;
            $display("ERROR tear_indicator wait timed out");
            results();
        end
    endtask
    task automatic drain;
        int n;
        for (n = 0; n < 300 && exp_pix.size() != 0; n++) @(posedge sys_clk);
        #2;
        if (exp_pix.size() != 0) begin
            errors++;
            $display("ERROR pixel drain timed out");
            results();
        end
    endtask
    initial begin : main_seq
        logic [31:0] r, x;
        logic [23:0] q, oe;
        int i, k;
        u_host.step(8);
        rst_n = 1'b1;
        u_host.step(4);
        for (i = 0; i < 3; i++) begin
            rnd(r);
            xfer(i, 1'b0, {2'b10, r[5:0]});
            xfer(i, 1'b1, r[15:8]);
        end
        power_state = host_port_pkg::PWR_DEEP_SLEEP;
        xfer(0, 1'b0, 8'h81);
        power_state = host_port_pkg::PWR_RESET;
        xfer(1, 1'b1, 8'h55);
        power_state = host_port_pkg::PWR_SLEEP;
        u_host.step(6);
        xfer(2, 1'b0, 8'h82);
        power_state = host_port_pkg::PWR_DISPLAY;
        // one pixel per 17-cycle write into a stalled fifo until it refuses
        xfer(0, 1'b0, host_port_pkg::CMD_PIXEL_IF);
        xfer(1, 1'b1, {5'h00, host_port_pkg::PIF_24});
        check("pixel_if", {21'h0, host_port_pkg::PIF_24}, {21'h0, pixel_if});
        wait_blank(1'b1);
        xfer(0, 1'b0, host_port_pkg::CMD_WRITE_MEM_START);
        for (i = 0; i < 33; i++) begin
            rnd(r);
            if (i < 32) exp_pix.push_back(r[23:0]);
            if (i == 32) check("fb_addr", 24'h000020, {3'h0, fb_addr});
            u_host.write(i % 3, 1'b1, r[23:0]);
        end
        check("pix_stall", 24'h1, {23'h0, pix_stall});
        pix_ready = 1'b1;
        drain();
        check("pix_stall", 24'h0, {23'h0, pix_stall});
        addr_decrement = 1'b1;
        wait_blank(1'b0);
        xfer(0, 1'b0, host_port_pkg::CMD_WRITE_MEM_START);
        for (i = 0; i < 2; i++) begin
            rnd(r);
            exp_pix.push_back(r[23:0]);
            u_host.write(0, 1'b1, r[23:0]);
        end
        check("fb_addr", 24'h1ffffe, {3'h0, fb_addr});
        drain();
        addr_decrement = 1'b0;
        // three byte cycles per pixel, each in another strobe style
        xfer(2, 1'b0, host_port_pkg::CMD_PIXEL_IF);
        xfer(0, 1'b1, {5'h00, host_port_pkg::PIF_8});
        xfer(1, 1'b0, host_port_pkg::CMD_WRITE_MEM_START);
        rnd(r);
        exp_pix.push_back(r[23:0]);
        for (k = 0; k < 3; k++) begin
            rnd(x);
            u_host.write(k, 1'b1, {x[23:8], r[23-8*k -: 8]});
        end
        drain();
        rnd(r);
        reg_read_byte = r[7:0];
        xfer(0, 1'b0, host_port_pkg::CMD_READ_MEM_START);
        u_host.read(q, oe);
        check("fb_addr", 24'h000001, {3'h0, fb_addr});
        check("fb_read_req", 24'h000001, 24'(fb_reqs));
        xfer(0, 1'b0, 8'h0a);
        u_host.read(q, oe);
        check("read_oe", 24'h0, {16'h0, oe[7:0]});
        check("read_data", {16'h0, r[7:0]}, {16'h0, q[7:0]});
        check("oe_idle", 24'hffffff, bus_oe_n);
        results();
    end
    initial begin : watchdog
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("ERROR run timed out");
        results();
    end
endmodule // host_port_tb_top
bind host_port host_port_properties u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .mode_strap(mode_strap), .cs_n(cs_n), .en_rd_n(en_rd_n), .rw_wr_n(rw_wr_n),
    .bus_oe_n(bus_oe_n), .tear_indicator(tear_indicator), .power_state(power_state),
    .addr_decrement(addr_decrement), .vertical_blank_window(vertical_blank_window),
    .horiz_blank(horiz_blank), .tear_with_horiz(tear_with_horiz), .cmd_valid(cmd_valid),
    .param_valid(param_valid), .pix_stall(pix_stall), .fb_addr(fb_addr),
    .pixel_if(pixel_if));
`default_nettype wire
